// ---- rtl/ptb_map.svh ----
// offsets, fields, reset values and timing counts of the pwm time base
`ifndef PTB_MAP_SVH
`define PTB_MAP_SVH
`define PTB_OFF_CTRL 12'h000
`define PTB_OFF_IRQEN 12'h004
`define PTB_OFF_PSC 12'h008
`define PTB_OFF_INIT 12'h00c
`define PTB_OFF_STAT 12'h010
`define PTB_OFF_CNT 12'h014
`define PTB_CTRL_DIR 4
`define PTB_CTRL_CMS_LO 5
`define PTB_CTRL_CMS_HI 6
`define PTB_CTRL_CKD_LO 8
`define PTB_CTRL_CKD_HI 9
`define PTB_CTRL_RST 16'h0081
`define PTB_IRQEN_RST 16'h0000
`define PTB_IRQEN_UIE 0
`define PTB_INIT_DIR 31
`define PTB_TICK_MIN 1
`endif

// ---- rtl/ptb_pkg.sv ----
// types of the pwm time base
package ptb_pkg;
  typedef enum logic [3:0] {
    PTB_EDGE = 4'h1,
    PTB_CTR_DN = 4'h2,
    PTB_CTR_UP = 4'h4,
    PTB_CTR_BOTH = 4'h8
  } ptb_mode_t;
  typedef struct packed {
    logic [1:0] align_select;
    logic dir;
    logic [1:0] deadtime_clock_divide;
  } ptb_cfg_t;
  typedef struct packed {
    logic [3:0] match_flag;
    logic wrap_flag;
  } ptb_flags_t;
endpackage : ptb_pkg

// ---- rtl/ptb_prescaler.sv ----
// prescaler that yields one tick per prescale_value plus one input clocks
`timescale 1ns/10ps
module ptb_prescaler #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic [WIDTH-1:0] prescale_value,
  output logic tick
);
  logic [WIDTH-1:0] div;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div <= '0;
    end else if (restart || div >= prescale_value) begin
      div <= '0;
    end else begin
      div <= div + 1'b1;
    end
  end
  assign tick = !restart && (div >= prescale_value);
endmodule : ptb_prescaler

// ---- rtl/ptb_timebase.sv ----
// pwm time base: prescaled auto-reload counter with apb registers
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/10ps
`include "ptb_map.svh"
module ptb_timebase #(
  parameter int CNT_W = 16,
  parameter int NUM_CH = 4,
  parameter bit HAS_DEADTIME = 1'b1
) (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [CNT_W-1:0] RELOAD_INPUT,
  input wire logic [4*CNT_W-1:0] COMPARE_VALUE,
  input wire logic SYNC,
  input wire logic [15:0] OUTPUT_ENABLE_POLARITY,
  output logic [15:0] OUTPUT_ENABLE_POLARITY_OUT,
  output logic [CNT_W-1:0] COUNT,
  output logic COUNT_UP,
  output logic [4*CNT_W-1:0] ACTIVE_COMPARE,
  output logic [3:0] MATCH_FLAG,
  output logic WRAP_FLAG,
  output logic [3:0] MATCH_IRQ,
  output logic WRAP_IRQ,
  output logic [1:0] DEADTIME_CLOCK_DIVIDE
);
  logic rst_s1, rst_n_s;
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_s1 <= 1'b0;
      rst_n_s <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n_s <= rst_s1;
    end
  end

  // sync pin: two stages then edge detect
  logic sync_s1, sync_s2, sync_d;
  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      sync_s1 <= 1'b0;
      sync_s2 <= 1'b0;
      sync_d <= 1'b0;
    end else begin
      sync_s1 <= SYNC;
      sync_s2 <= sync_s1;
      sync_d <= sync_s2;
    end
  end
  logic sync_rise;
  assign sync_rise = sync_s2 && !sync_d;

  // software registers
  logic [15:0] ctrl, irqen, psc;
  logic [CNT_W-1:0] init_cnt;
  logic init_down;
  logic wr_en, rd_en;
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && PENABLE && !PWRITE;
  assign PREADY = 1'b1;
  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      ctrl <= `PTB_CTRL_RST;
      irqen <= `PTB_IRQEN_RST;
      psc <= 16'h0000;
      init_cnt <= '0;
      init_down <= 1'b0;
    end else if (wr_en) begin
      case (PADDR)
        `PTB_OFF_CTRL: ctrl <= PWDATA[15:0];
        `PTB_OFF_IRQEN: irqen <= PWDATA[15:0];
        `PTB_OFF_PSC: psc <= PWDATA[15:0];
        `PTB_OFF_INIT: begin
          init_cnt <= PWDATA[CNT_W-1:0];
          init_down <= PWDATA[`PTB_INIT_DIR];
        end
        default: ;
      endcase
    end
  end
  logic addr_ok;
  always_comb begin
    case (PADDR)
      `PTB_OFF_CTRL, `PTB_OFF_IRQEN, `PTB_OFF_PSC, `PTB_OFF_INIT,
      `PTB_OFF_STAT, `PTB_OFF_CNT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign PSLVERR = PSEL && PENABLE && !addr_ok;

  // prescaler restarts on init write and on sync
  logic init_wr, tick;
  assign init_wr = wr_en && PADDR == `PTB_OFF_INIT;
  ptb_prescaler #(.WIDTH(16)) u_psc (
    .clk(CLOCK),
    .rst_n(rst_n_s),
    .restart(sync_rise || init_wr || !rst_n_s),
    .prescale_value(psc),
    .tick(tick)
  );

  // active configuration, loaded at wrap events, sync and init writes
  ptb_pkg::ptb_cfg_t cfg;
  logic [CNT_W-1:0] reload_input;
  logic [4*CNT_W-1:0] ccr;
  ptb_pkg::ptb_mode_t mode;
  always_comb begin
    case (cfg.align_select)
      2'h0: mode = ptb_pkg::PTB_EDGE;
      2'h1: mode = ptb_pkg::PTB_CTR_DN;
      2'h2: mode = ptb_pkg::PTB_CTR_UP;
      default: mode = ptb_pkg::PTB_CTR_BOTH;
    endcase
  end

  logic [CNT_W-1:0] cnt, next_cnt;
  logic up, next_up, wrap;
  always_comb begin
    next_cnt = cnt;
    next_up = up;
    wrap = 1'b0;
    if (tick) begin
      case (mode)
        ptb_pkg::PTB_EDGE: begin
          if (!cfg.dir) begin
            next_up = 1'b1;
            if (cnt >= reload_input) begin
              next_cnt = '0;
              wrap = 1'b1;
            end else begin
              next_cnt = cnt + 1'b1;
            end
          end else begin
            next_up = 1'b0;
            if (cnt == '0) begin
              next_cnt = reload_input;
              wrap = 1'b1;
            end else begin
              next_cnt = cnt - 1'b1;
            end
          end
        end
        default: begin
          if (up) begin
            if (cnt + 1'b1 >= reload_input) begin
              next_up = 1'b0;
              wrap = 1'b1;
            end
            next_cnt = cnt + 1'b1;
          end else begin
            if (cnt <= 1) begin
              next_up = 1'b1;
              wrap = 1'b1;
            end
            next_cnt = (cnt == '0) ? cnt : cnt - 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      cnt <= '0;
      up <= 1'b1;
    end else if (sync_rise) begin
      cnt <= '0;
      up <= 1'b1;
    end else if (init_wr) begin
      cnt <= PWDATA[CNT_W-1:0];
      up <= !PWDATA[`PTB_INIT_DIR];
    end else begin
      cnt <= next_cnt;
      up <= next_up;
    end
  end

  // preload at wrap events, sync or init write
  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      cfg <= '0;
      reload_input <= '0;
      ccr <= '0;
    end else if (wrap || sync_rise || init_wr) begin
      cfg.align_select <= ctrl[`PTB_CTRL_CMS_HI:`PTB_CTRL_CMS_LO];
      cfg.dir <= ctrl[`PTB_CTRL_DIR];
      cfg.deadtime_clock_divide <= HAS_DEADTIME ?
        ctrl[`PTB_CTRL_CKD_HI:`PTB_CTRL_CKD_LO] : 2'h0;
      reload_input <= RELOAD_INPUT;
      ccr <= COMPARE_VALUE;
    end
  end

  ptb_pkg::ptb_flags_t next_flags, flags;
  logic dir_ok;
  always_comb begin
    case (mode)
      ptb_pkg::PTB_CTR_DN: dir_ok = !up;
      ptb_pkg::PTB_CTR_UP: dir_ok = up;
      default: dir_ok = 1'b1;
    endcase
    next_flags.wrap_flag = wrap;
    for (int i = 0; i < 4; i++) begin
      next_flags.match_flag[i] = tick && dir_ok && (i < NUM_CH) &&
        (next_cnt == ccr[i*CNT_W +: CNT_W]);
    end
  end
  always_ff @(posedge CLOCK or negedge rst_n_s) begin
    if (!rst_n_s) begin
      flags <= '0;
    end else begin
      flags <= next_flags;
    end
  end

  assign MATCH_FLAG = flags.match_flag;
  assign WRAP_FLAG = flags.wrap_flag;
  logic [3:0] ch_mask;
  assign ch_mask = 4'hf >> (4 - NUM_CH);
  assign MATCH_IRQ = flags.match_flag & irqen[4:1] & ch_mask;
  assign WRAP_IRQ = flags.wrap_flag & irqen[`PTB_IRQEN_UIE];
  assign OUTPUT_ENABLE_POLARITY_OUT = OUTPUT_ENABLE_POLARITY;
  assign COUNT = cnt;
  assign COUNT_UP = up;
  assign ACTIVE_COMPARE = ccr;
  assign DEADTIME_CLOCK_DIVIDE = cfg.deadtime_clock_divide;

  always_comb begin
    PRDATA = 32'h0000_0000;
    if (rd_en) begin
      case (PADDR)
        `PTB_OFF_CTRL: PRDATA = {16'h0000, ctrl};
        `PTB_OFF_IRQEN: PRDATA = {16'h0000, irqen};
        `PTB_OFF_PSC: PRDATA = {16'h0000, psc};
        `PTB_OFF_INIT: PRDATA = 32'(init_cnt) | {init_down, 31'h0};
        `PTB_OFF_STAT: PRDATA = {29'h0, up, cfg.align_select};
        `PTB_OFF_CNT: PRDATA = 32'(cnt);
        default: PRDATA = 32'h0000_0000;
      endcase
    end
  end

  property p_wrap_pulse;
    @(posedge CLOCK) disable iff (!rst_n_s)
      wrap |=> WRAP_FLAG ##1 (WRAP_FLAG == $past(wrap));
  endproperty
  a_wrap_pulse: assert property (p_wrap_pulse) else $error("wrap pulse wrong");
  property p_up_wrap;
    @(posedge CLOCK) disable iff (!rst_n_s)
      (mode == ptb_pkg::PTB_EDGE && !cfg.dir && tick && cnt >= reload_input && !sync_rise && !init_wr)
      |=> cnt == '0;
  endproperty
  a_up_wrap: assert property (p_up_wrap) else $error("up wrap missed");
  property p_down_wrap;
    @(posedge CLOCK) disable iff (!rst_n_s)
      (mode == ptb_pkg::PTB_EDGE && cfg.dir && tick && cnt == '0 && !sync_rise && !init_wr)
      |=> cnt == $past(reload_input);
  endproperty
  a_down_wrap: assert property (p_down_wrap) else $error("down reload missed");
  property p_sync;
    @(posedge CLOCK) disable iff (!rst_n_s)
      sync_rise |=> cnt == '0 && reload_input == $past(RELOAD_INPUT);
  endproperty
  a_sync: assert property (p_sync) else $error("sync not applied");
  property p_hold;
    @(posedge CLOCK) disable iff (!rst_n_s)
      !tick && !sync_rise && !init_wr |=> $stable(cnt);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved off tick");
  property p_preload;
    @(posedge CLOCK) disable iff (!rst_n_s)
      !wrap && !sync_rise && !init_wr |=> $stable(reload_input) && $stable(ccr);
  endproperty
  a_preload: assert property (p_preload) else $error("config changed early");
  property p_irq;
    @(posedge CLOCK) disable iff (!rst_n_s)
      WRAP_IRQ |-> WRAP_FLAG && irqen[`PTB_IRQEN_UIE];
  endproperty
  a_irq: assert property (p_irq) else $error("irq not gated");
  property p_match;
    @(posedge CLOCK) disable iff (!rst_n_s)
      MATCH_FLAG[0] |-> cnt == $past(ccr[CNT_W-1:0]);
  endproperty
  a_match: assert property (p_match) else $error("match without equality");
  property p_center_dir;
    @(posedge CLOCK) disable iff (!rst_n_s)
      (mode != ptb_pkg::PTB_EDGE && up && tick && cnt + 1'b1 >= reload_input && !sync_rise && !init_wr)
      |=> !up;
  endproperty
  a_center_dir: assert property (p_center_dir) else $error("no turn at top");
endmodule : ptb_timebase

// ---- test/ptb_stage_model.sv ----
// far-side model: output reference levels driven by match pulses
`timescale 1ns/10ps
module ptb_stage_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] match_flag,
  input wire logic [15:0] oe_pol,
  output logic [3:0] ref_level,
  output logic [3:0] pin_level
);
  // toggle mode: each match pulse flips the reference
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_level <= 4'h0;
    end else begin
      ref_level <= ref_level ^ match_flag;
    end
  end
  // polarity applied straight, never latched
  assign pin_level = ref_level ^ {oe_pol[13], oe_pol[9], oe_pol[5], oe_pol[1]};
endmodule : ptb_stage_model

// ---- test/pwm_timebase_counter_tb.sv ----
// self-checking bench of the pwm time base
`timescale 1ns/10ps
`include "ptb_map.svh"
module pwm_timebase_counter_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic sync = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] reload = 16'h0004;
  logic [15:0] oep = 16'h0000;
  logic [63:0] cmp = 64'h2;
  logic [31:0] prdata;
  logic pready, pslverr, cnt_up, wf, wirq, er;
  logic [15:0] oep_out, cnt;
  logic [63:0] act;
  logic [3:0] mf, mirq, ref_level, pin_level;
  logic [1:0] dtcd;
  logic [31:0] rd;
  int q = 0;
  int fail_count = 0;
  int check_count = 0;
  always #4 clk = ~clk;
  ptb_timebase DUT (.CLOCK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RELOAD_INPUT(reload), .COMPARE_VALUE(cmp), .SYNC(sync), .OUTPUT_ENABLE_POLARITY(oep),
    .OUTPUT_ENABLE_POLARITY_OUT(oep_out), .COUNT(cnt), .COUNT_UP(cnt_up),
    .ACTIVE_COMPARE(act), .MATCH_FLAG(mf), .WRAP_FLAG(wf), .MATCH_IRQ(mirq),
    .WRAP_IRQ(wirq), .DEADTIME_CLOCK_DIVIDE(dtcd));
  ptb_stage_model PARTNER (.clk(clk), .rst_n(rst_n), .match_flag(mf), .oe_pol(oep_out),
    .ref_level(ref_level), .pin_level(pin_level));
  task automatic results;
    if (fail_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 50) begin
      fail_count++;
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic cfg(input logic [31:0] c, input logic [31:0] p, input logic [31:0] n);
    apb(1'b1, `PTB_OFF_CTRL, c);
    apb(1'b1, `PTB_OFF_PSC, p);
    apb(1'b1, `PTB_OFF_INIT, n);
  endtask : cfg
  task automatic span(output int len, output int m, output int w, output int mx);
    int i;
    #1;
    for (i = 0; i < 300 && wf !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    if (i == 300) begin
      fail_count++;
      results();
    end
    len = 0;
    m = 0;
    w = 0;
    mx = 0;
    q = 0;
    do begin
      @(posedge clk);
      #1;
      len++;
      m += mf[0];
      w += wirq;
      q += mirq[0];
      if (cnt > mx) mx = cnt;
    end while (wf !== 1'b1 && len < 300);
  endtask : span
  task automatic t_reset;
    apb(1'b0, `PTB_OFF_CTRL, 32'h0);
    chk("ctrl reset", 32'h0081, rd);
    apb(1'b0, `PTB_OFF_IRQEN, 32'h0);
    chk("irqen reset", 32'h0, rd);
    chk("reset dir", 32'h1, {31'h0, cnt_up});
    apb(1'b1, 12'h020, 32'hffff);
    chk("unmapped error", 32'h1, {31'h0, er});
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped read", 32'h0, rd);
  endtask : t_reset
  task automatic t_edge;
    int l, m, w, x;
    apb(1'b1, `PTB_OFF_IRQEN, 32'h1f);
    cfg(32'h0281, 32'h2, 32'h0);
    #1;
    chk("divide", 32'h2, {30'h0, dtcd});
    span(l, m, w, x);
    chk("up period", 15, l);
    chk("up top", 4, x);
    chk("up matches", 1, m);
    chk("wrap irq on", 1, w);
    chk("match irq on", 1, q);
    apb(1'b1, `PTB_OFF_IRQEN, 32'h0);
    span(l, m, w, x);
    chk("wrap irq off", 0, w);
    chk("match irq off", 0, q);
    chk("matches ungated", 1, m);
    cfg(32'h0091, 32'h0, 32'h0);
    span(l, m, w, x);
    chk("down period", 5, l);
    chk("down top", 4, x);
    chk("down dir", 32'h0, {31'h0, cnt_up});
  endtask : t_edge
  task automatic t_center;
    int l1, l2, m1, m2, w, x;
    for (int k = 1; k < 4; k++) begin
      cfg(32'h0081 | (k << 5), 32'h0, 32'h0);
      span(l1, m1, w, x);
      span(l2, m2, w, x);
      chk("half one", 4, l1);
      chk("half two", 4, l2);
      chk("center matches", (k == 3) ? 2 : 1, m1 + m2);
      chk("center top", 4, x);
    end
  endtask : t_center
  task automatic t_preload;
    int l, m, w, x;
    cfg(32'h0081, 32'h0, 32'h0);
    span(l, m, w, x);
    @(posedge clk);
    reload <= 16'd6;
    cmp <= 64'h3;
    oep <= 16'h0022;
    #1;
    chk("polarity out", 32'h0022, {16'h0, oep_out});
    chk("pin polarity", 32'h3, {28'h0, pin_level ^ ref_level});
    chk("compare held", 32'h2, {16'h0, act[15:0]});
    span(l, m, w, x);
    chk("new period", 7, l);
    chk("new compare", 32'h3, {16'h0, act[15:0]});
    span(l, m, w, x);
    @(posedge clk);
    reload <= 16'd40;
    cmp <= 64'h5;
    sync <= 1'b1;
    for (int i = 0; i < 10 && act[15:0] !== 16'h0005; i++) begin
      @(posedge clk);
      #1;
    end
    chk("sync compare", 32'h5, {16'h0, act[15:0]});
    chk("sync count", 32'h0, {16'h0, cnt});
    span(l, m, w, x);
    chk("sync period", 41, l);
    @(posedge clk);
    sync <= 1'b0;
  endtask : t_preload
  task automatic t_init;
    cfg(32'h00e1, 32'h7, 32'h80000003);
    #1;
    chk("init count", 32'h3, {16'h0, cnt});
    chk("init dir", 32'h0, {31'h0, cnt_up});
    apb(1'b0, `PTB_OFF_STAT, 32'h0);
    chk("init state", 32'h3, rd);
  endtask : t_init
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_edge();
    t_center();
    t_preload();
    t_init();
    results();
  end
endmodule : pwm_timebase_counter_tb
